// ---- include/irk_defs.vh ----
// constants for the remote keypad selector
// assumes a 25 MHz pclk; included by design/irk_selector.v
`ifndef IRK_DEFS_VH
`define IRK_DEFS_VH
`define IRK_CLK_HZ       25000000
`define IRK_IDLE_SEC     30
`define IRK_HOLD_SEC     3
`define IRK_IDLE_CYC     (`IRK_IDLE_SEC * `IRK_CLK_HZ)
`define IRK_HOLD_CYC     (`IRK_HOLD_SEC * `IRK_CLK_HZ)
`define IRK_BLINK_CYC    6250000
`define IRK_MAX_IN_RST   6'h20
`define IRK_MAX_OUT_RST  6'h10
`define IRK_SW_RST       3'h1
`define IRK_SW_MAX       7'h04
// key codes: 0..9 digits, then function keys
`define IRK_KEY_SYS      4'ha
`define IRK_KEY_OUT      4'hb
`define IRK_KEY_IN       4'hc
// display glyph codes for the two entry digits
`define IRK_GL_BLANK     5'h10
`define IRK_GL_E         5'h11
`define IRK_GL_C         5'h12
`define IRK_GL_I         5'h13
`define IRK_GL_O         5'h14
// apb register map
`define IRK_A_CTRL       12'h000
`define IRK_A_STAT       12'h004
`define IRK_A_IRQ        12'h008
`define IRK_A_MASK       12'h00c
`define IRK_A_FRAME      12'h010
`define IRK_A_DISP       12'h014
`define IRK_A_LIMIT      12'h018
// irq bits
`define IRK_IRQ_TX       0
`define IRK_IRQ_ERR      1
`define IRK_IRQ_CFG      2
`define IRK_IRQ_SLEEP    3
`endif

// ---- design/irk_selector.v ----
// keypad entry controller: keys in, lcd glyphs and ir frame strobe out
// assumes key events are one-cycle pulses synchronous to pclk; apb slave
// Function
// [R1] any key wakes blank display
// [R2] 30 s without key blanks display
// [R3] first digit shows switch with point
// [R4] last two digits show entry, newest blinks
// [R5] entry is two-digit shifting buffer
// [R6] function key without digits shows error
// [R7] select key accepts 1..4 else error
// [R8] output above maximum shows error, no send
// [R9] input above maximum shows error, no send
// [R10] valid port sent tagged, blinking stops
// [R11] repeated key re-sends same selection
// [R12] receiver indicator follows output/input frames
// [R13] reset maxima 32 inputs, 16 outputs
// [R14] hold select 3 s from blank: config
// [R15] config stores maximum, shows i or o
// [R16] config over limit: config error, keep
// [R17] low battery lights right point when active
// [R18] switch number 1..4, default 1
// [R19] frame: switch, direction bit, port
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "irk_defs.vh"
module irk_selector
#(
	parameter [31:0] idle_cycles = `IRK_IDLE_CYC,
	parameter [31:0] hold_cycles = `IRK_HOLD_CYC,
	parameter [31:0] blink_cycles = `IRK_BLINK_CYC
)
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        key_valid,
	input  wire [3:0]  key_code,
	input  wire        sys_key_held,
	input  wire        low_battery,
	output reg         lcd_on,
	output reg  [2:0]  lcd_switch,
	output reg         lcd_switch_point,
	output reg  [4:0]  lcd_tens,
	output reg  [4:0]  lcd_units,
	output reg         lcd_mid_point,
	output reg         lcd_units_blank,
	output reg         low_battery_point,
	output reg         ir_frame_valid,
	output reg  [9:0]  ir_frame,
	output wire        irq
);
	localparam [3:0] st_sleep = 4'b0001;
	localparam [3:0] st_act   = 4'b0010;
	localparam [3:0] st_hold  = 4'b0100;
	localparam [3:0] st_cfg   = 4'b1000;

	reg  [3:0]  state;
	reg  [31:0] idle_cnt;
	reg  [31:0] hold_cnt;
	reg  [31:0] blink_cnt;
	reg         blink_phase;
	reg  [3:0]  dig_hi;
	reg  [3:0]  dig_lo;
	reg  [1:0]  ndig;
	reg         blinking;
	reg  [2:0]  cur_sw;
	reg  [5:0]  max_in;
	reg  [5:0]  max_out;
	reg  [4:0]  gl_tens;
	reg  [4:0]  gl_units;
	reg         gl_point;
	reg         last_dir;
	reg  [5:0]  last_port;
	reg         last_ok;
	reg  [3:0]  irq_stat;
	reg  [3:0]  irq_mask;
	reg         sw_wake;
	reg  [3:0]  ev;

	wire [6:0] entry = {3'h0, dig_hi} * 7'd10 + {3'h0, dig_lo};
	wire       is_digit = key_valid && (key_code < 4'ha);
	wire       is_sys = key_valid && (key_code == `IRK_KEY_SYS);
	wire       is_out = key_valid && (key_code == `IRK_KEY_OUT);
	wire       is_in  = key_valid && (key_code == `IRK_KEY_IN);
	wire       wr = psel && penable && pwrite;

	// decoding of a value 0..99 into tens/units glyphs, used once, for the DISP register read
	function [9:0] split;
		input [6:0] v;
		reg   [6:0] t;
		reg   [6:0] u;
		begin
			t = v / 7'd10;
			u = v % 7'd10;
			split = {t[4:0], u[4:0]};
		end
	endfunction

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(irq_stat & irq_mask);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= st_sleep;
			idle_cnt <= 32'h0;
			hold_cnt <= 32'h0;
			dig_hi <= 4'h0;
			dig_lo <= 4'h0;
			ndig <= 2'h0;
			blinking <= 1'b0;
			cur_sw <= `IRK_SW_RST; // [R18]
			max_in <= `IRK_MAX_IN_RST; // [R13]
			max_out <= `IRK_MAX_OUT_RST; // [R13]
			gl_tens <= `IRK_GL_BLANK;
			gl_units <= `IRK_GL_BLANK;
			gl_point <= 1'b0;
			last_dir <= 1'b0;
			last_port <= 6'h0;
			last_ok <= 1'b0;
			ir_frame_valid <= 1'b0;
			ir_frame <= 10'h0;
			ev <= 4'h0;
		end
		else
		begin
			ir_frame_valid <= 1'b0;
			ev <= 4'h0;
			if (key_valid || sw_wake)
				idle_cnt <= 32'h0;
			else if (state != st_sleep)
				idle_cnt <= idle_cnt + 32'h1;
			case (state)
			st_sleep:
			begin
				hold_cnt <= 32'h0;
				if (is_sys)
				begin
					// error shown while the hold is timed
					state <= st_hold; // [R1]
					gl_tens <= `IRK_GL_E; // [R14]
					gl_units <= `IRK_GL_E;
					gl_point <= 1'b0;
					ndig <= 2'h0;
					blinking <= 1'b0;
				end
				else if (key_valid || sw_wake)
				begin
					state <= st_act; // [R1]
					ndig <= 2'h0;
					blinking <= 1'b0;
					gl_tens <= `IRK_GL_BLANK;
					gl_units <= `IRK_GL_BLANK;
					gl_point <= 1'b0;
					if (is_digit)
					begin
						dig_hi <= 4'h0;
						dig_lo <= key_code;
						ndig <= 2'h1;
						blinking <= 1'b1;
					end
					else if (key_valid)
					begin
						gl_tens <= `IRK_GL_E; // [R6]
						gl_units <= `IRK_GL_E;
						ev[`IRK_IRQ_ERR] <= 1'b1;
					end
				end
			end
			st_hold:
			begin
				// no idle timeout here: the hold itself is being timed
				if (!sys_key_held)
					state <= st_act;
				else if (hold_cnt >= hold_cycles - 32'h1)
				begin
					state <= st_cfg; // [R14]
					gl_tens <= `IRK_GL_BLANK;
					gl_units <= `IRK_GL_C;
					ndig <= 2'h0;
				end
				else
					hold_cnt <= hold_cnt + 32'h1;
			end
			default:
			begin
				if (idle_cnt >= idle_cycles - 32'h1 && !key_valid)
				begin
					state <= st_sleep; // [R2]
					ev[`IRK_IRQ_SLEEP] <= 1'b1;
				end
				else if (is_digit)
				begin
					// a fresh entry must not inherit digits of an earlier one
					dig_hi <= (ndig == 2'h0) ? 4'h0 : dig_lo; // [R5]
					dig_lo <= key_code; // [R5]
					if (ndig != 2'h2)
						ndig <= ndig + 2'h1;
					blinking <= 1'b1; // [R4]
					last_ok <= 1'b0;
				end
				else if (state == st_cfg && (is_in || is_out))
				begin
					state <= st_act; // [R15]
					blinking <= 1'b0;
					ndig <= 2'h0;
					if (ndig == 2'h0 || (is_in && entry > {1'b0, `IRK_MAX_IN_RST})
						|| (is_out && entry > {1'b0, `IRK_MAX_OUT_RST}))
					begin
						gl_point <= 1'b1; // [R16]
						gl_tens <= `IRK_GL_C;
						gl_units <= `IRK_GL_E;
						ev[`IRK_IRQ_ERR] <= 1'b1;
					end
					else
					begin
						if (is_in)
							max_in <= entry[5:0]; // [R15]
						else
							max_out <= entry[5:0]; // [R15]
						gl_point <= 1'b0;
						gl_tens <= is_in ? `IRK_GL_I : `IRK_GL_O;
						gl_units <= {1'b0, dig_lo};
						ev[`IRK_IRQ_CFG] <= 1'b1;
					end
				end
				else if (state == st_act && (is_sys || is_out || is_in))
				begin
					blinking <= 1'b0; // [R10]
					gl_point <= 1'b0;
					ndig <= 2'h0;
					if ((is_out || is_in) && ndig == 2'h0 && last_ok)
					begin
						ir_frame_valid <= 1'b1; // [R11]
						ir_frame <= {cur_sw[1:0] - 2'h1, last_dir, 1'b0, last_port}; // [R19]
						ev[`IRK_IRQ_TX] <= 1'b1;
					end
					else if (ndig == 2'h0 || (is_sys && (entry == 7'h0 || entry > `IRK_SW_MAX))
						|| (is_out && entry > {1'b0, max_out}) // [R8]
						|| (is_in && entry > {1'b0, max_in})) // [R9]
					begin
						gl_tens <= `IRK_GL_E; // [R6] [R7]
						gl_units <= `IRK_GL_E;
						last_ok <= 1'b0;
						ev[`IRK_IRQ_ERR] <= 1'b1;
					end
					else if (is_sys)
					begin
						cur_sw <= entry[2:0]; // [R7] [R18]
						gl_tens <= `IRK_GL_BLANK;
						gl_units <= `IRK_GL_BLANK;
						last_ok <= 1'b0;
					end
					else
					begin
						// frame kept so the same key can repeat it
						ir_frame_valid <= 1'b1; // [R10]
						// bit 6 is spare and kept zero so direction sits at bit 7
						ir_frame <= {cur_sw[1:0] - 2'h1, is_in, 1'b0, entry[5:0]}; // [R19]
						last_dir <= is_in;
						last_port <= entry[5:0];
						last_ok <= 1'b1;
						ev[`IRK_IRQ_TX] <= 1'b1;
					end
				end
			end
			endcase
		end
	end

	// blink timer
	// free-running, so the first blink phase of an entry may be short
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blink_cnt <= 32'h0;
			blink_phase <= 1'b0;
		end
		else if (blink_cnt >= blink_cycles - 32'h1)
		begin
			blink_cnt <= 32'h0;
			blink_phase <= ~blink_phase;
		end
		else
			blink_cnt <= blink_cnt + 32'h1;
	end

	// display drive, registered
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lcd_on <= 1'b0;
			lcd_switch <= 3'h0;
			lcd_switch_point <= 1'b0;
			lcd_tens <= `IRK_GL_BLANK;
			lcd_units <= `IRK_GL_BLANK;
			lcd_mid_point <= 1'b0;
			lcd_units_blank <= 1'b0;
			low_battery_point <= 1'b0;
		end
		else
		begin
			lcd_on <= (state != st_sleep); // [R2]
			lcd_switch <= cur_sw; // [R3]
			lcd_switch_point <= (state != st_sleep); // [R3]
			lcd_mid_point <= gl_point;
			low_battery_point <= low_battery && (state != st_sleep); // [R17]
			if (ndig != 2'h0)
			begin
				lcd_tens <= (ndig == 2'h2) ? {1'b0, dig_hi} : `IRK_GL_BLANK; // [R4]
				lcd_units <= {1'b0, dig_lo}; // [R4]
			end
			else
			begin
				lcd_tens <= gl_tens;
				lcd_units <= gl_units;
			end
			lcd_units_blank <= blinking && blink_phase; // [R4]
		end
	end

	// apb registers; status bits set wins over write-one-clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			sw_wake <= 1'b0;
		end
		else
		begin
			sw_wake <= wr && paddr == `IRK_A_CTRL && pwdata[0];
			if (wr && paddr == `IRK_A_MASK)
				irq_mask <= pwdata[3:0];
			if (wr && paddr == `IRK_A_IRQ)
				irq_stat <= (irq_stat & ~pwdata[3:0]) | ev;
			else
				irq_stat <= irq_stat | ev;
		end
	end

	// read word captured in the setup cycle, so prdata comes from flip-flops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable)
		begin
			case (paddr)
			`IRK_A_CTRL:  prdata <= 32'h0;
			`IRK_A_STAT:  prdata <= {20'h0, low_battery, blinking, ndig, state, 1'b0, cur_sw};
			`IRK_A_IRQ:   prdata <= {28'h0, irq_stat};
			`IRK_A_MASK:  prdata <= {28'h0, irq_mask};
			`IRK_A_FRAME: prdata <= {21'h0, last_ok, ir_frame};
			`IRK_A_DISP:  prdata <= {22'h0, split(entry)};
			`IRK_A_LIMIT: prdata <= {18'h0, max_out, 2'h0, max_in};
			default:      prdata <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- bench/irk_rx_model.sv ----
// stand-in for the switch-side infrared receiver
// assumes one-cycle frame pulses from irk_selector
`timescale 1ns/100ps
`default_nettype none
module irk_rx_model
#(
	parameter [1:0] own_sw = 2'h0
)
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire       fv,
	input  wire [9:0] fr,
	output logic      led
);
	// frames for other switches leave the led alone
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			led <= 1'h0;
		else if (fv && fr[9:8] == own_sw)
			led <= !fr[7];
endmodule
`default_nettype wire

// ---- bench/irk_selector_props.sv ----
// port assertions for the keypad selector
// assumes bind onto irk_selector, pclk domain only
`timescale 1ns/100ps
`default_nettype none
`include "irk_defs.vh"
module irk_selector_props
#(
	parameter [31:0] idle_cycles = 32'hc8
)
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire        key_valid,
	input wire [3:0]  key_code,
	input wire        sys_key_held,
	input wire        low_battery,
	input wire        lcd_on,
	input wire [2:0]  lcd_switch,
	input wire        low_battery_point,
	input wire        ir_frame_valid,
	input wire [9:0]  ir_frame
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reg [31:0] idle;
	// margin of 16 so the exact timer edge is not pinned
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			idle <= 32'h0;
		else if (key_valid || sys_key_held || (psel && pwrite && paddr == `IRK_A_CTRL))
			idle <= 32'h0;
		else if (idle < idle_cycles + 32'h10)
			idle <= idle + 32'h1;
	chk_switch_range: assert property (lcd_on |-> lcd_switch >= 3'h1 && lcd_switch <= 3'h4)
		else $error("switch number out of range");
	chk_wake_digit: assert property (key_valid && !lcd_on && key_code <= 4'h9 |-> ##[1:3] lcd_on)
		else $error("digit key did not wake display");
	chk_idle_blank: assert property (idle == idle_cycles + 32'h10 |-> !lcd_on)
		else $error("display still on after idle time");
	chk_lowbat_on: assert property (low_battery && lcd_on ##1 low_battery && lcd_on |-> low_battery_point)
		else $error("low battery point dark");
	chk_lowbat_off: assert property (!low_battery ##1 !low_battery |-> !low_battery_point)
		else $error("low battery point lit without cause");
	chk_frame_cause: assert property (ir_frame_valid |-> $past(key_valid) && ($past(key_code) == `IRK_KEY_OUT || $past(key_code) == `IRK_KEY_IN))
		else $error("frame without port key");
	chk_frame_switch: assert property (ir_frame_valid |-> {1'h0, ir_frame[9:8]} == lcd_switch - 3'h1)
		else $error("frame switch field wrong");
	chk_frame_port: assert property (ir_frame_valid |-> ir_frame[5:0] <= (ir_frame[7] ? 6'h20 : 6'h10))
		else $error("frame port above limit");
	chk_select_silent: assert property (key_valid && key_code == `IRK_KEY_SYS |=> !ir_frame_valid)
		else $error("select key sent a frame");
endmodule
bind irk_selector irk_selector_props #(.idle_cycles(idle_cycles)) i_props (.pclk, .presetn,
	.psel, .pwrite, .paddr, .key_valid, .key_code, .sys_key_held, .low_battery, .lcd_on,
	.lcd_switch, .low_battery_point, .ir_frame_valid, .ir_frame);
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for irk_selector with receiver model
// assumes shortened timers; frames checked from a queue
`timescale 1ns/100ps
`default_nettype none
`include "irk_defs.vh"
`define CHK(a, b) \
	check_count++; \
	if ((a) !== (b)) \
	begin \
		n_fail++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, a, b); \
	end
module tb_top;
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        key_valid = 1'h0, sys_key_held = 1'h0, low_battery = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0]  key_code = 4'h0;
	logic [7:0]  rnd = 8'h29;
	logic [9:0]  e, expq[$];
	int          n_fail = 0, check_count = 0, cyc = 0, p, nb;
	wire [31:0]  prdata;
	wire [9:0]   ir_frame;
	wire [4:0]   lcd_tens, lcd_units;
	wire [2:0]   lcd_switch;
	wire         pready, irq, lcd_on, lcd_switch_point, lcd_mid_point;
	wire         low_battery_point, ir_frame_valid, led, lcd_units_blank;
	irk_selector #(.idle_cycles(32'hc8), .hold_cycles(32'h32), .blink_cycles(32'h8)) i_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr(), .key_valid, .key_code, .sys_key_held, .low_battery, .lcd_on, .lcd_switch,
		.lcd_switch_point, .lcd_tens, .lcd_units, .lcd_mid_point, .lcd_units_blank,
		.low_battery_point, .ir_frame_valid, .ir_frame, .irq);
	irk_rx_model i_rx (.pclk, .presetn, .fv(ir_frame_valid), .fr(ir_frame), .led);
	always #20 pclk = ~pclk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// counts blanked-units samples over two blink half-periods
	task blink_count(output int hi);
		hi = 0;
		repeat (16)
		begin
			@(posedge pclk);
			hi += int'(lcd_units_blank);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task key(input logic [3:0] c);
		@(posedge pclk);
		key_valid <= 1'h1;
		key_code <= c;
		@(posedge pclk);
		key_valid <= 1'h0;
		repeat (4) @(posedge pclk);
	endtask
	task num(input int n);
		key(4'(n / 10));
		key(4'(n % 10));
	endtask
	// config entry from blank: hold select past the shortened hold time
	task cfg_enter;
		repeat (230) @(posedge pclk);
		sys_key_held <= 1'h1;
		key(`IRK_KEY_SYS);
		`CHK({lcd_tens, lcd_units}, {`IRK_GL_E, `IRK_GL_E})
		repeat (60) @(posedge pclk);
		`CHK({lcd_tens, lcd_units}, {`IRK_GL_BLANK, `IRK_GL_C})
		sys_key_held <= 1'h0;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (ir_frame_valid)
		begin
			e = expq.size() ? expq.pop_front() : 10'h3ff;
			`CHK(ir_frame, e)
		end
		if (cyc == 20000)
		begin
			n_fail++;
			conclude();
		end
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `IRK_A_LIMIT, 32'h0);
		`CHK(rd[13:0], 14'h1020)
		key(`IRK_KEY_OUT);
		`CHK({lcd_on, lcd_tens, lcd_units}, {1'h1, `IRK_GL_E, `IRK_GL_E})
		key(4'h1);
		key(4'h2);
		key(4'h3);
		`CHK({lcd_tens, lcd_units}, 10'h043)
		`CHK({lcd_switch, lcd_switch_point}, 4'h3)
		blink_count(nb);
		`CHK(nb > 0 && nb < 16, 1'h1)
		key(`IRK_KEY_OUT);
		`CHK({lcd_tens, lcd_units}, {`IRK_GL_E, `IRK_GL_E})
		num(5);
		expq.push_back(10'h005);
		expq.push_back(10'h005);
		key(`IRK_KEY_OUT);
		`CHK(led, 1'h1)
		blink_count(nb);
		`CHK(nb, 0)
		key(`IRK_KEY_OUT);
		apb(1'h1, `IRK_A_MASK, 32'h1);
		`CHK(irq, 1'h1)
		apb(1'h1, `IRK_A_IRQ, 32'h1);
		`CHK(irq, 1'h0)
		rnd = lfsr(rnd);
		p = 1 + rnd % 32;
		num(p);
		expq.push_back(10'h080 | 10'(p));
		key(`IRK_KEY_IN);
		`CHK(led, 1'h0)
		num(33);
		key(`IRK_KEY_IN);
		`CHK({lcd_tens, lcd_units}, {`IRK_GL_E, `IRK_GL_E})
		key(4'h3);
		key(`IRK_KEY_SYS);
		`CHK({lcd_switch, lcd_units}, {3'h3, `IRK_GL_BLANK})
		key(4'h5);
		key(`IRK_KEY_SYS);
		`CHK(lcd_switch, 3'h3)
		low_battery <= 1'h1;
		key(4'h1);
		`CHK(low_battery_point, 1'h1)
		repeat (230) @(posedge pclk);
		`CHK(lcd_on, 1'h0)
		key(4'h7);
		`CHK({lcd_on, lcd_units}, {1'h1, 5'h07})
		cfg_enter();
		num(8);
		key(`IRK_KEY_OUT);
		`CHK({lcd_tens, lcd_units}, {`IRK_GL_O, 5'h08})
		cfg_enter();
		num(17);
		key(`IRK_KEY_OUT);
		`CHK({lcd_tens, lcd_mid_point, lcd_units}, {`IRK_GL_C, 1'h1, `IRK_GL_E})
		apb(1'h0, `IRK_A_LIMIT, 32'h0);
		`CHK(rd[13:8], 6'h08)
		`CHK(expq.size(), 0)
		conclude();
	end
endmodule
`default_nettype wire
